// ---- verilog/rtpm_pkg.sv ----
`default_nettype none
package rtpm_pkg;
    // register byte addresses
    localparam logic [7:0]  CMD_OFF      = 8'h88;
    localparam logic [7:0]  PERF_OFF     = 8'h8C;
    localparam logic [7:0]  PM_OFF       = 8'h90;
    // command_config fields
    localparam int          AUTO_UNDERRUN_RECOVERY_BIT     = 0;
    localparam int          SOFTWARE_IRQ_BIT     = 1;
    localparam int          DRT_LSB      = 2;
    localparam int          RTE_BIT      = 4;
    localparam int          PAUSE_BIT    = 5;
    // bus_perf_counter fields
    localparam int          CLK_LSB      = 16;
    localparam int          CLK_W        = 16;
    localparam int          DW_LSB       = 0;
    localparam int          DW_W         = 8;
    // power_mgmt_ctrl_status fields
    localparam int          WAKE_EN_BIT  = 8;
    localparam int          SEL_LSB      = 9;
    localparam int          SCALE_LSB    = 13;
    localparam int          WAKE_ST_BIT  = 15;
    // receive threshold codes
    localparam logic [1:0]  THR_32       = 2'h0;
    localparam logic [1:0]  THR_64       = 2'h1;
    localparam logic [1:0]  THR_SF       = 2'h2;
    // reset values
    localparam logic [1:0]  DRT_RST      = 2'h1;
    localparam logic        RTE_RST      = 1'b0;
    localparam logic        SOFTWARE_IRQ_RST     = 1'b0;
    localparam logic        AUTO_UNDERRUN_RECOVERY_RST     = 1'b0;
    localparam logic        PAUSE_RST    = 1'b0;
    localparam logic        WAKE_EN_RST  = 1'b0;
    localparam logic [3:0]  DATA_SELECT_VAL     = 4'h0;
    localparam logic [1:0]  DATA_SCALE_VAL    = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ANS  = 2'b10
    } rtpm_apb_e;
endpackage
`default_nettype wire

// ---- verilog/rtpm_sat_acc.sv ----
`default_nettype none
module rtpm_sat_acc #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    // control
    input  wire logic             inc,
    input  wire logic             clr,
    // state
    output logic [WIDTH-1:0]      count_reg
);
    logic [WIDTH-1:0] count_next;
    logic [WIDTH-1:0] base;

    if (WIDTH < 1 || WIDTH > 32)
    begin : g_chk
        $error("rtpm_sat_acc: WIDTH out of range");
    end

    // an event in the clearing cycle counts from zero, so it is not lost
    always_comb
    begin
        base       = clr ? '0 : count_reg;
        count_next = base;
        if (inc && (base != {WIDTH{1'b1}}))
        begin
            count_next = base + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            count_reg <= '0;
        else
            count_reg <= count_next;
    end

    property p_sat_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        (count_reg == {WIDTH{1'b1}}) && !clr |=> (count_reg == {WIDTH{1'b1}});
    endproperty
    a_sat_hold: assert property (p_sat_hold) else $error("counter left saturation without clear");
endmodule
`default_nettype wire

// ---- verilog/rtpm_wake_ctl.sv ----
`default_nettype none
module rtpm_wake_ctl (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset_n,
    // events and control
    input  wire logic wake_event,
    input  wire logic status_clr,
    input  wire logic sig_en,
    // state
    output logic      wake_status_reg,
    output logic      pme_oe_n_reg
);
    logic wake_status_next;
    logic pme_oe_n_next;

    always_comb
    begin
        // set wins over a simultaneous write-one clear
        wake_status_next = wake_event | (wake_status_reg & ~status_clr);
        pme_oe_n_next    = ~(wake_status_next & sig_en);
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wake_status_reg <= 1'b0;
            pme_oe_n_reg    <= 1'b1;
        end
        else
        begin
            wake_status_reg <= wake_status_next;
            pme_oe_n_reg    <= pme_oe_n_next;
        end
    end

    property p_no_pme_disabled;
        @(posedge ref_clk) disable iff (!reset_n)
        !sig_en |=> pme_oe_n_reg;
    endproperty
    a_no_pme_disabled: assert property (p_no_pme_disabled) else $error("pme driven while disabled");

    property p_wake_sets;
        @(posedge ref_clk) disable iff (!reset_n)
        wake_event |=> wake_status_reg;
    endproperty
    a_wake_sets: assert property (p_wake_sets) else $error("wake event did not set status");
endmodule
`default_nettype wire

// ---- verilog/rtpm_regs.sv ----
// Design decision made here: the APB interface to the registers.
`default_nettype none
module rtpm_regs (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    // auto-negotiation
    input  wire logic                        an_done,
    input  wire logic                        an_pause,
    // bus activity
    input  wire logic                        rd_pending,
    input  wire logic                        dword_xfer,
    // wake and config mirror
    input  wire logic                        wake_event,
    input  wire logic                        cfg_pm_wr,
    input  wire logic [15:0]                 cfg_pm_wdata,
    output logic [15:0]                      cfg_pm_rdata,
    // pme pin, open drain
    input  wire logic                        pme_i,
    output logic                             pme_o,
    output logic                             pme_oe_n,
    // controls to the datapath
    output logic                             pause_en,
    output logic [1:0]                       rx_thresh_sel,
    output logic                             software_irq,
    output logic                             auto_underrun_recovery
);
    import rtpm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    rtpm_apb_e          state_reg;
    rtpm_apb_e          state_next;
    logic [31:0]        prdata_reg;
    logic [31:0]        prdata_next;
    logic               pslverr_reg;
    logic               pslverr_next;
    logic               access;
    logic               wr_fire;
    logic               capture;
    logic               cmd_wr;
    logic               pm_wr;
    logic               perf_clr;
    logic               mapped;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    assign access   = psel && penable;
    assign capture  = access && (state_reg == ST_IDLE);
    assign wr_fire  = access && (state_reg == ST_ANS) && pwrite;
    assign cmd_wr   = wr_fire && hit(paddr, CMD_OFF);
    assign pm_wr    = wr_fire && hit(paddr, PM_OFF);
    assign mapped   = hit(paddr, CMD_OFF) || hit(paddr, PERF_OFF) || hit(paddr, PM_OFF);
    // cleared at the capture edge so no event between capture and answer is lost
    assign perf_clr = capture && !pwrite && hit(paddr, PERF_OFF);

    ////////////////////////////////////////////////////////////////////////
    logic               an_seen_reg;
    logic               an_seen_next;
    logic               an_cmpl_reg;
    logic               an_cmpl_next;
    logic               pause_reg;
    logic               pause_next;
    logic               rte_reg;
    logic               rte_next;
    logic [1:0]         drt_reg;
    logic [1:0]         drt_next;
    logic               software_irq_reg;
    logic               software_irq_next;
    logic               auto_underrun_recovery_reg;
    logic               auto_underrun_recovery_next;
    logic [1:0]         thr_reg;
    logic [1:0]         thr_next;
    logic               wake_en_reg;
    logic               wake_en_next;
    logic               an_rise;
    logic               wake_clr;
    logic [CLK_W-1:0]   clk_cnt;
    logic [DW_W-1:0]    dw_cnt;
    logic               wake_status;

    assign an_rise  = an_done && !an_seen_reg;
    // either location may clear the flag; both see one shared bit
    assign wake_clr = (pm_wr && pwdata[WAKE_ST_BIT]) ||
                      (cfg_pm_wr && cfg_pm_wdata[WAKE_ST_BIT]);

    always_comb
    begin
        state_next   = state_reg;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (access)
                begin
                    state_next   = ST_ANS;
                    pslverr_next = !mapped;
                    prdata_next  = 32'h0000_0000;
                    if (!pwrite)
                    begin
                        if (hit(paddr, CMD_OFF))
                            prdata_next = {26'h0, pause_reg, rte_reg, drt_reg, software_irq_reg, auto_underrun_recovery_reg};
                        else if (hit(paddr, PERF_OFF))
                            prdata_next = {clk_cnt, 8'h00, dw_cnt};
                        else if (hit(paddr, PM_OFF))
                            prdata_next = {16'h0000, wake_status, DATA_SCALE_VAL, DATA_SELECT_VAL,
                                           wake_en_reg, 8'h00};
                    end
                end
            end
            ST_ANS:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_comb
    begin
        an_seen_next = an_done;
        an_cmpl_next = an_cmpl_reg || an_done;
        pause_next   = pause_reg;
        rte_next     = rte_reg;
        drt_next     = drt_reg;
        software_irq_next    = software_irq_reg;
        auto_underrun_recovery_next    = auto_underrun_recovery_reg;
        wake_en_next = wake_en_reg;
        if (cmd_wr)
        begin
            rte_next  = pwdata[RTE_BIT];
            drt_next  = pwdata[DRT_LSB +: 2];
            software_irq_next = pwdata[SOFTWARE_IRQ_BIT];
            auto_underrun_recovery_next = pwdata[AUTO_UNDERRUN_RECOVERY_BIT];
            if (an_cmpl_reg)
                pause_next = pwdata[PAUSE_BIT];
        end
        if (an_rise)
            pause_next = an_pause;
        // scale and select bits of either write are dropped
        if (pm_wr)
            wake_en_next = pwdata[WAKE_EN_BIT];
        if (cfg_pm_wr)
            wake_en_next = cfg_pm_wdata[WAKE_EN_BIT];
        thr_next = rte_next ? drt_next : THR_64;
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg   <= ST_IDLE;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
            an_seen_reg <= 1'b0;
            an_cmpl_reg <= 1'b0;
            pause_reg   <= PAUSE_RST;
            rte_reg     <= RTE_RST;
            drt_reg     <= DRT_RST;
            software_irq_reg    <= SOFTWARE_IRQ_RST;
            auto_underrun_recovery_reg    <= AUTO_UNDERRUN_RECOVERY_RST;
            thr_reg     <= THR_64;
            wake_en_reg <= WAKE_EN_RST;
        end
        else
        begin
            state_reg   <= state_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
            an_seen_reg <= an_seen_next;
            an_cmpl_reg <= an_cmpl_next;
            pause_reg   <= pause_next;
            rte_reg     <= rte_next;
            drt_reg     <= drt_next;
            software_irq_reg    <= software_irq_next;
            auto_underrun_recovery_reg    <= auto_underrun_recovery_next;
            thr_reg     <= thr_next;
            wake_en_reg <= wake_en_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    rtpm_sat_acc #(
        .WIDTH (CLK_W)
    ) u_lat_cnt (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .inc       (rd_pending),
        .clr       (perf_clr),
        .count_reg (clk_cnt)
    );

    rtpm_sat_acc #(
        .WIDTH (DW_W)
    ) u_dw_cnt (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .inc       (dword_xfer),
        .clr       (perf_clr),
        .count_reg (dw_cnt)
    );

    rtpm_wake_ctl u_wake (
        .ref_clk         (ref_clk),
        .reset_n         (reset_n),
        .wake_event      (wake_event),
        .status_clr      (wake_clr),
        .sig_en          (wake_en_next),
        .wake_status_reg (wake_status),
        .pme_oe_n_reg    (pme_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // pin input unused: the device only pulls the line low
    logic pme_unused;
    assign pme_unused             = pme_i;
    assign pme_o                  = 1'b0;
    assign prdata                 = prdata_reg;
    assign pready                 = state_reg[1]; // one-hot answer bit, straight from the flop
    assign pslverr                = pslverr_reg;
    assign pause_en               = pause_reg;
    assign rx_thresh_sel          = thr_reg;
    assign software_irq           = software_irq_reg;
    assign auto_underrun_recovery = auto_underrun_recovery_reg;
    assign cfg_pm_rdata           = {wake_status, DATA_SCALE_VAL, DATA_SELECT_VAL, wake_en_reg, 8'h00};

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_perf_read;
        perf_clr ##1 (pready && !pslverr);
    endsequence

    property p_an_load;
        an_rise |=> (pause_en == $past(an_pause));
    endproperty
    a_an_load: assert property (p_an_load) else $error("pause not loaded from negotiation");

    property p_pause_locked;
        cmd_wr && !an_cmpl_reg && !an_rise |=> $stable(pause_en);
    endproperty
    a_pause_locked: assert property (p_pause_locked) else $error("pause written before negotiation");

    property p_rte_off;
        cmd_wr && !pwdata[RTE_BIT] |=> (rx_thresh_sel == THR_64);
    endproperty
    a_rte_off: assert property (p_rte_off) else $error("threshold not forced to 64 bytes");

    property p_drt_sel;
        cmd_wr && pwdata[RTE_BIT] |=> (rx_thresh_sel == $past(pwdata[DRT_LSB +: 2]));
    endproperty
    a_drt_sel: assert property (p_drt_sel) else $error("drain threshold not selected");

    property p_auto_underrun_recovery;
        cmd_wr |=> (auto_underrun_recovery == $past(pwdata[AUTO_UNDERRUN_RECOVERY_BIT]));
    endproperty
    a_auto_underrun_recovery: assert property (p_auto_underrun_recovery) else $error("underrun recovery bit wrong");

    property p_lat_count;
        rd_pending && !perf_clr && (clk_cnt != 16'hFFFF) |=> (clk_cnt == $past(clk_cnt) + 16'h0001);
    endproperty
    a_lat_count: assert property (p_lat_count) else $error("latency clock not counted");

    property p_perf_clear;
        s_perf_read |-> (prdata[CLK_LSB +: CLK_W] == $past(clk_cnt)) && (clk_cnt <= 16'h0001);
    endproperty
    a_perf_clear: assert property (p_perf_clear) else $error("counter read or clear wrong");

    property p_dw_clear;
        perf_clr && !dword_xfer |=> (dw_cnt == 8'h00);
    endproperty
    a_dw_clear: assert property (p_dw_clear) else $error("dword count not cleared");

    property p_wake_w1c;
        wake_clr && !wake_event |=> !wake_status ##1 (!wake_status || $past(wake_event));
    endproperty
    a_wake_w1c: assert property (p_wake_w1c) else $error("wake status not cleared");

    property p_wake_w0;
        pm_wr && !pwdata[WAKE_ST_BIT] && !cfg_pm_wr && wake_status |=> wake_status;
    endproperty
    a_wake_w0: assert property (p_wake_w0) else $error("write zero changed wake status");

    property p_pm_zero;
        pready && hit(paddr, PM_OFF) && !pwrite |-> (prdata[15:9] ==? {1'b?, 6'h00});
    endproperty
    a_pm_zero: assert property (p_pm_zero) else $error("scale or select not zero");

    property p_mirror;
        cfg_pm_wr && !pm_wr |=> (cfg_pm_rdata[WAKE_EN_BIT] == $past(cfg_pm_wdata[WAKE_EN_BIT]));
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror write not seen");

    property p_software_irq_hold;
        software_irq && !cmd_wr |=> software_irq;
    endproperty
    a_software_irq_hold: assert property (p_software_irq_hold) else $error("software interrupt dropped");
endmodule
`default_nettype wire

// ---- dv/test_rtpm_regs.sv ----
`default_nettype none
module test_rtpm_regs import rtpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // clock and reset
    logic        ref_clk;
    logic        reset_n;
    // apb
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // side inputs
    logic        an_done;
    logic        an_pause;
    logic        rd_pending;
    logic        dword_xfer;
    logic        wake_event;
    logic        cfg_pm_wr;
    logic [15:0] cfg_pm_wdata;
    logic [15:0] cfg_pm_rdata;
    // pme pin and controls
    logic        pme_i;
    logic        pme_o;
    logic        pme_oe_n;
    logic        pause_en;
    logic [1:0]  rx_thresh_sel;
    logic        software_irq;
    logic        auto_underrun_recovery;
    // bookkeeping
    int          num_errors;
    int          checked;
    logic [31:0] rd;
    logic        err;

    // open drain wire with pull-up: low only while the block drives it
    assign pme_i = pme_oe_n ? 1'b1 : pme_o;

    rtpm_regs DUT (
        .ref_clk                (ref_clk),
        .reset_n                (reset_n),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .an_done                (an_done),
        .an_pause               (an_pause),
        .rd_pending             (rd_pending),
        .dword_xfer             (dword_xfer),
        .wake_event             (wake_event),
        .cfg_pm_wr              (cfg_pm_wr),
        .cfg_pm_wdata           (cfg_pm_wdata),
        .cfg_pm_rdata           (cfg_pm_rdata),
        .pme_i                  (pme_i),
        .pme_o                  (pme_o),
        .pme_oe_n               (pme_oe_n),
        .pause_en               (pause_en),
        .rx_thresh_sel          (rx_thresh_sel),
        .software_irq           (software_irq),
        .auto_underrun_recovery (auto_underrun_recovery)
    );

    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // one full apb transfer; pready sampled at the rising edge only
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge ref_clk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 16)
        begin
            num_errors++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int i;
        num_errors   = 0;
        checked      = 0;
        reset_n      = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0000_0000;
        an_done      = 1'b0;
        an_pause     = 1'b0;
        rd_pending   = 1'b0;
        dword_xfer   = 1'b0;
        wake_event   = 1'b0;
        cfg_pm_wr    = 1'b0;
        cfg_pm_wdata = 16'h0000;
        tick(12);
        reset_n <= 1'b1;
        chk(32'(rx_thresh_sel), 32'(THR_64));
        chk(32'(software_irq), 32'h0);
        chk(32'(auto_underrun_recovery), 32'h0);
        chk(32'(pme_oe_n), 32'h1);
        rdc(CMD_OFF, 32'(DRT_RST) << DRT_LSB);
        rdc(PERF_OFF, 32'h0000_0000);
        rdc(PM_OFF, 32'h0000_0000);
        // pause bit locked until negotiation is done
        wr(CMD_OFF, 32'h1 << PAUSE_BIT);
        tick(1);
        chk(32'(pause_en), 32'h0);
        an_pause <= 1'b1;
        an_done  <= 1'b1;
        tick(3);
        chk(32'(pause_en), 32'h1);
        wr(CMD_OFF, 32'h0000_0000);
        tick(1);
        chk(32'(pause_en), 32'h0);
        // every drain code, reserved one included
        for (i = 0; i < 4; i++)
        begin
            wr(CMD_OFF, (32'h1 << RTE_BIT) | (32'(i) << DRT_LSB));
            tick(1);
            chk(32'(rx_thresh_sel), 32'(i));
            rdc(CMD_OFF, (32'h1 << RTE_BIT) | (32'(i) << DRT_LSB));
        end
        wr(CMD_OFF, 32'(THR_32) << DRT_LSB);
        tick(1);
        chk(32'(rx_thresh_sel), 32'(THR_64));
        wr(CMD_OFF, (32'h1 << AUTO_UNDERRUN_RECOVERY_BIT) | (32'h1 << SOFTWARE_IRQ_BIT));
        tick(5);
        chk(32'(auto_underrun_recovery), 32'h1);
        chk(32'(software_irq), 32'h1);
        wr(CMD_OFF, 32'h1 << AUTO_UNDERRUN_RECOVERY_BIT);
        tick(1);
        chk(32'(software_irq), 32'h0);
        // counters: 37 latency clocks, 45 dwords
        rd_pending <= 1'b1;
        dword_xfer <= 1'b1;
        tick(37);
        rd_pending <= 1'b0;
        tick(8);
        dword_xfer <= 1'b0;
        rdc(PERF_OFF, (32'd37 << CLK_LSB) | (32'd45 << DW_LSB));
        rdc(PERF_OFF, 32'h0000_0000);
        // dword field must stick at its top value
        dword_xfer <= 1'b1;
        tick(300);
        dword_xfer <= 1'b0;
        rdc(PERF_OFF, 32'h0000_00FF);
        dword_xfer <= 1'b1;
        tick(3);
        dword_xfer <= 1'b0;
        rdc(PERF_OFF, 32'h0000_0003);
        // wake with signalling disabled: status only
        wake_event <= 1'b1;
        tick(1);
        wake_event <= 1'b0;
        tick(3);
        chk(32'(pme_oe_n), 32'h1);
        chk(32'(cfg_pm_rdata), 32'h0000_8000);
        rdc(PM_OFF, 32'h1 << WAKE_ST_BIT);
        wr(PM_OFF, 32'h0000_7E00);
        rdc(PM_OFF, 32'h1 << WAKE_ST_BIT);
        wr(PM_OFF, 32'h1 << WAKE_ST_BIT);
        rdc(PM_OFF, 32'h0000_0000);
        wr(PM_OFF, 32'h1 << WAKE_EN_BIT);
        tick(1);
        chk(32'(cfg_pm_rdata), 32'h0000_0100);
        chk(32'(pme_oe_n), 32'h1);
        wake_event <= 1'b1;
        tick(1);
        wake_event <= 1'b0;
        tick(3);
        chk(32'(pme_oe_n), 32'h0);
        chk(32'(pme_i), 32'h0);
        wr(PM_OFF, (32'h1 << WAKE_ST_BIT) | (32'h1 << WAKE_EN_BIT));
        tick(2);
        chk(32'(pme_oe_n), 32'h1);
        // config-side write must show through the apb view
        wake_event <= 1'b1;
        tick(1);
        wake_event <= 1'b0;
        tick(1);
        chk(32'(cfg_pm_rdata), 32'h0000_8100);
        cfg_pm_wr    <= 1'b1;
        cfg_pm_wdata <= 16'h8000;
        tick(1);
        cfg_pm_wr <= 1'b0;
        tick(1);
        rdc(PM_OFF, 32'h0000_0000);
        chk(32'(pme_oe_n), 32'h1);
        // unmapped place: refused, and the command word untouched
        wr(8'h94, 32'hFFFF_FFFF);
        chk(32'(err), 32'h1);
        rdc(8'h94, 32'h0000_0000);
        rdc(CMD_OFF, 32'h1 << AUTO_UNDERRUN_RECOVERY_BIT);
        end_sim();
    end
endmodule
`default_nettype wire
